// [core/pcc_top.sv]
// Operation
// - Power field 01 holds the PLL down
// - Bypass bit routes source past VCO divider
// - Source bit 0 selects external clock input
// - Power field 00 gives normal PLL operation
// - Polarity bit sets loop sense
// - Settings apply only after update write 0x01
// - Detector compares reference and feedback edges
// - Two-bit field sets anti-backlash width
// - Pump mode: hiz, normal, forced up, down
// - Pump current in eight equal steps
// - Polarity applies only with external VCO
// - Calibration starts on committed bit rise
// - VCO divider field selects two to six
`timescale 1ns/10ps
`default_nettype none
module pcc_top import pcc_pkg::*; #(
   parameter int PADDR_W = 12
) (
   input  wire logic               i_clk,          // 125 MHz clock
   input  wire logic               i_reset,        // Synchronous reset, high
   input  wire logic               i_psel,         // APB select
   input  wire logic               i_penable,      // APB enable
   input  wire logic               i_pwrite,       // APB direction
   input  wire logic [PADDR_W-1:0] i_paddr,        // APB byte address
   input  wire logic [31:0]        i_pwdata,       // APB write data
   output logic                    o_pready,       // APB ready
   output logic [31:0]             o_prdata,       // APB read data
   output logic                    o_pslverr,      // APB error, unmapped
   input  wire logic               i_ref_div,      // Reference divider output
   input  wire logic               i_fb_div,       // Feedback divider output
   output logic                    o_pll_power_down, // PLL held off
   output logic                    o_pll_enable,   // PLL normal operation
   output logic                    o_pfd_invert,   // Negative loop sense
   output logic [1:0]              o_backlash_sel, // Anti-backlash width
   output logic                    o_pump_up,      // Charge pump source
   output logic                    o_pump_down,    // Charge pump sink
   output logic [2:0]              o_pump_current_code, // Current step
   output logic [2:0]              o_vco_div_ratio, // Divide ratio 2..6
   output logic                    o_div_bypass,   // Skip VCO divider
   output logic                    o_src_vco,      // Internal VCO source
   output logic                    o_cal_busy,     // Calibration running
   output logic                    o_cal_done      // Calibration finished
);

   typedef struct packed {
      pcc_cfg_s    stg;
      pcc_cfg_s    act;
      logic [2:0]  ref_s;
      logic [2:0]  fb_s;
      logic        ref_lvl;
      logic        fb_lvl;
      logic        up;
      logic        dn;
      logic [2:0]  abl_cnt;
      pcc_cal_e    cal_st;
      logic [7:0]  cal_cnt;
      logic        busy;
      logic        done;
      logic        pready;
      logic [31:0] prdata;
      logic        pslverr;
      logic        pll_pd;
      logic        pll_en;
      logic        pfd_inv;
      logic        pump_up;
      logic        pump_dn;
      logic [2:0]  ratio;
   } pcc_state_s;

   pcc_state_s st;
   pcc_state_s next_st;

   logic [9:0] idx;
   logic       acc;
   logic       wr;
   logic       commit;
   logic       ref_edge;
   logic       fb_edge;
   logic       abl_clr;

   // Index from the word address; low bits ignored
   assign idx    = i_paddr[11:2];
   assign acc    = i_psel && i_penable && st.pready;
   assign wr     = acc && i_pwrite;
   assign commit = wr && (idx == PCC_IDX_UPDATE) && (i_pwdata[7:0] == PCC_UPDATE_KEY);

   // All next-state logic in one place
   always_comb begin
      next_st = st;
      ref_edge = 1'b0;
      fb_edge  = 1'b0;
      abl_clr  = 1'b0;
      // One wait state keeps pready a plain flop
      next_st.pready  = i_psel && i_penable && !st.pready;
      next_st.pslverr = 1'b0;
      next_st.prdata  = 32'h0000_0000;
      if (i_psel && i_penable && !st.pready && !i_pwrite) begin
         if (idx == PCC_IDX_PLL_CTRL) begin
            next_st.prdata[7:0] = {st.stg.pol, st.stg.pump, 2'b00, st.stg.power};
         end else if (idx == PCC_IDX_BACKLASH) begin
            next_st.prdata[1:0] = st.stg.abl;
         end else if (idx == PCC_IDX_CAL_CTRL) begin
            next_st.prdata[0] = st.stg.cal;
         end else if (idx == PCC_IDX_PUMP_CUR) begin
            next_st.prdata[2:0] = st.stg.cur;
         end else if (idx == PCC_IDX_STATUS) begin
            next_st.prdata[1:0] = {st.cal_st == PCC_CAL_DONE, st.cal_st == PCC_CAL_RUN};
         end else if (idx == PCC_IDX_VCO_DIV) begin
            next_st.prdata[2:0] = st.stg.vdiv;
         end else if (idx == PCC_IDX_SRC_SEL) begin
            next_st.prdata[1:0] = {st.stg.src_vco, st.stg.bypass};
         end else if (idx == PCC_IDX_UPDATE) begin
            next_st.prdata = 32'h0000_0000; // Trigger reads as zero
         end else begin
            next_st.pslverr = 1'b1;
         end
      end else if (i_psel && i_penable && !st.pready) begin
         if (idx != PCC_IDX_PLL_CTRL && idx != PCC_IDX_BACKLASH && idx != PCC_IDX_CAL_CTRL &&
             idx != PCC_IDX_PUMP_CUR && idx != PCC_IDX_STATUS && idx != PCC_IDX_VCO_DIV &&
             idx != PCC_IDX_SRC_SEL && idx != PCC_IDX_UPDATE) begin
            next_st.pslverr = 1'b1;
         end
      end

      // Staged writes; nothing reaches the hardware yet
      if (wr) begin
         if (idx == PCC_IDX_PLL_CTRL) begin
            next_st.stg.power = i_pwdata[PCC_POWER_LSB +: 2];
            next_st.stg.pump  = i_pwdata[PCC_PUMP_LSB +: 3];
            next_st.stg.pol   = i_pwdata[PCC_POL_BIT];
         end else if (idx == PCC_IDX_BACKLASH) begin
            next_st.stg.abl = i_pwdata[1:0];
         end else if (idx == PCC_IDX_CAL_CTRL) begin
            next_st.stg.cal = i_pwdata[0];
         end else if (idx == PCC_IDX_PUMP_CUR) begin
            next_st.stg.cur = i_pwdata[2:0];
         end else if (idx == PCC_IDX_VCO_DIV) begin
            next_st.stg.vdiv = i_pwdata[2:0];
         end else if (idx == PCC_IDX_SRC_SEL) begin
            next_st.stg.bypass  = i_pwdata[PCC_BYPASS_BIT];
            next_st.stg.src_vco = i_pwdata[PCC_SRC_BIT];
         end
      end

      // Staged set becomes active in one step
      if (commit) begin
         next_st.act = st.stg;
      end

      // Three-stage sync; level moves once stages two and three agree
      next_st.ref_s = {st.ref_s[1:0], i_ref_div};
      next_st.fb_s  = {st.fb_s[1:0], i_fb_div};
      if (st.ref_s[1] == st.ref_s[2]) begin
         next_st.ref_lvl = st.ref_s[2];
      end
      if (st.fb_s[1] == st.fb_s[2]) begin
         next_st.fb_lvl = st.fb_s[2];
      end
      ref_edge = next_st.ref_lvl && !st.ref_lvl;
      fb_edge  = next_st.fb_lvl && !st.fb_lvl;

      // Detector: reference edge pumps up, feedback edge pumps down
      if (st.up && st.dn) begin
         next_st.abl_cnt = st.abl_cnt + 3'h1;
         abl_clr = (st.abl_cnt >= PCC_ABL_BASE + {1'b0, st.act.abl});
      end else begin
         next_st.abl_cnt = 3'h0;
      end
      next_st.up = ref_edge || (st.up && !abl_clr);
      next_st.dn = fb_edge || (st.dn && !abl_clr);
      if (abl_clr) begin
         next_st.abl_cnt = 3'h0;
      end

      // Calibration sequencer counts reference edges
      case (st.cal_st)
         PCC_CAL_IDLE: begin
            if (commit && st.stg.cal && !st.act.cal) begin
               next_st.cal_st  = PCC_CAL_RUN;
               next_st.cal_cnt = 8'h00;
            end
         end
         PCC_CAL_RUN: begin
            // Abort first, so a last edge in the same cycle still ends the run
            if (commit && !st.stg.cal) begin
               next_st.cal_st = PCC_CAL_IDLE;
            end
            if (ref_edge) begin
               next_st.cal_cnt = st.cal_cnt + 8'h01;
               if (st.cal_cnt == PCC_CAL_EDGES - 8'h01) begin
                  next_st.cal_st = PCC_CAL_DONE;
               end
            end
         end
         PCC_CAL_DONE: begin
            // Clearing the bit rearms for a later run
            if (commit && !st.stg.cal) begin
               next_st.cal_st = PCC_CAL_IDLE;
            end
         end
         default: begin
            next_st.cal_st = PCC_CAL_IDLE;
         end
      endcase
      next_st.busy = (next_st.cal_st == PCC_CAL_RUN);
      next_st.done = (next_st.cal_st == PCC_CAL_DONE);

      // Decoded outputs follow the active set in the same cycle
      next_st.pll_pd  = (next_st.act.power != PCC_PWR_NORMAL);
      next_st.pll_en  = (next_st.act.power == PCC_PWR_NORMAL);
      // Internal VCO has a fixed sense, so polarity is masked there
      next_st.pfd_inv = next_st.act.pol && !next_st.act.src_vco;
      if (next_st.act.vdiv > PCC_VCO_DIV_MAX) begin
         next_st.ratio = PCC_VCO_DIV_MAX + PCC_DIV_OFFSET;
      end else begin
         next_st.ratio = next_st.act.vdiv + PCC_DIV_OFFSET;
      end

      // Pump steering by mode; powered-down PLL never pumps
      next_st.pump_up = 1'b0;
      next_st.pump_dn = 1'b0;
      if (next_st.pll_en) begin
         case (next_st.act.pump)
            PCC_PUMP_FUP: begin
               next_st.pump_up = 1'b1;
            end
            PCC_PUMP_FDOWN: begin
               next_st.pump_dn = 1'b1;
            end
            PCC_PUMP_NORMAL: begin
               next_st.pump_up = next_st.pfd_inv ? next_st.dn : next_st.up;
               next_st.pump_dn = next_st.pfd_inv ? next_st.up : next_st.dn;
            end
            default: begin
               next_st.pump_up = 1'b0;
            end
         endcase
      end
   end

   // State register; reset gives distribution-only defaults
   always_ff @(posedge i_clk) begin
      if (i_reset) begin
         st              <= '0;
         st.stg.power    <= PCC_PWR_DOWN;
         st.act.power    <= PCC_PWR_DOWN;
         st.stg.vdiv     <= PCC_VCO_DIV_RST;
         st.act.vdiv     <= PCC_VCO_DIV_RST;
         st.pll_pd       <= 1'b1;
         st.ratio        <= PCC_VCO_DIV_RST + PCC_DIV_OFFSET;
      end else begin
         st <= next_st;
      end
   end

   // Outputs straight from the state flops
   assign o_pready            = st.pready;
   assign o_prdata            = st.prdata;
   assign o_pslverr           = st.pslverr;
   assign o_pll_power_down    = st.pll_pd;
   assign o_pll_enable        = st.pll_en;
   assign o_pfd_invert        = st.pfd_inv;
   assign o_backlash_sel      = st.act.abl;
   assign o_pump_up           = st.pump_up;
   assign o_pump_down         = st.pump_dn;
   assign o_pump_current_code = st.act.cur;
   assign o_vco_div_ratio     = st.ratio;
   assign o_div_bypass        = st.act.bypass;
   assign o_src_vco           = st.act.src_vco;
   assign o_cal_busy          = st.busy;
   assign o_cal_done          = st.done;

   // Checks
   sequence s_commit;
      i_psel && i_penable && st.pready && i_pwrite && (idx == PCC_IDX_UPDATE) &&
      (i_pwdata[7:0] == PCC_UPDATE_KEY);
   endsequence

   chk_update_gate: assert property (
      @(posedge i_clk) disable iff (i_reset)
      !commit |=> $stable({o_div_bypass, o_src_vco, o_backlash_sel, o_pump_current_code, o_vco_div_ratio}))
      else $error("Active setting changed without update");
   chk_power_down: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and (st.stg.power == PCC_PWR_DOWN) |=> o_pll_power_down && !o_pll_enable)
      else $error("PLL not held down");
   chk_power_on: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and (st.stg.power == PCC_PWR_NORMAL) |=> o_pll_enable && !o_pll_power_down)
      else $error("PLL not in normal operation");
   chk_bypass_route: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit |=> (o_div_bypass == $past(st.stg.bypass)))
      else $error("Bypass not applied");
   chk_source_sel: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and !st.stg.src_vco |=> !o_src_vco)
      else $error("External input not selected");
   chk_polarity_ext: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and st.stg.pol and !st.stg.src_vco |=> o_pfd_invert)
      else $error("Polarity not applied");
   chk_polarity_int: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and st.stg.src_vco |=> !o_pfd_invert)
      else $error("Polarity leaked to internal VCO");
   chk_pump_quiet: assert property (
      @(posedge i_clk) disable iff (i_reset)
      (o_pump_up || o_pump_down) |-> o_pll_enable && (st.act.pump != PCC_PUMP_HIZ))
      else $error("Pump active while off or hiz");
   chk_pump_force: assert property (
      @(posedge i_clk) disable iff (i_reset)
      o_pll_enable && (st.act.pump == PCC_PUMP_FUP) |-> o_pump_up && !o_pump_down)
      else $error("Forced pump up wrong");
   chk_ref_edge: assert property (
      @(posedge i_clk) disable iff (i_reset)
      $rose(st.ref_lvl) |-> st.up)
      else $error("Reference edge did not pump up");
   chk_backlash_end: assert property (
      @(posedge i_clk) disable iff (i_reset)
      $rose(st.up && st.dn) |-> (st.up && st.dn) [*2] ##[0:4] !(st.up && st.dn))
      else $error("Anti-backlash width wrong");
   chk_current_code: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit |=> (o_pump_current_code == $past(st.stg.cur)))
      else $error("Pump current not applied");
   chk_cal_start: assert property (
      @(posedge i_clk) disable iff (i_reset)
      s_commit and st.stg.cal and !st.act.cal and (st.cal_st == PCC_CAL_IDLE) |=> o_cal_busy)
      else $error("Calibration did not start");
   chk_div_ratio: assert property (
      @(posedge i_clk) disable iff (i_reset)
      o_vco_div_ratio >= 3'd2 && o_vco_div_ratio <= 3'd6)
      else $error("VCO divide ratio out of range");

endmodule
`default_nettype wire

// [core/pcc_pkg.sv]
package pcc_pkg;
   // Register indices; byte address is four times the index
   localparam logic [9:0] PCC_IDX_PLL_CTRL   = 10'h010;
   localparam logic [9:0] PCC_IDX_BACKLASH   = 10'h017;
   localparam logic [9:0] PCC_IDX_CAL_CTRL   = 10'h018;
   localparam logic [9:0] PCC_IDX_PUMP_CUR   = 10'h019;
   localparam logic [9:0] PCC_IDX_STATUS     = 10'h01F;
   localparam logic [9:0] PCC_IDX_VCO_DIV    = 10'h1E0;
   localparam logic [9:0] PCC_IDX_SRC_SEL    = 10'h1E1;
   localparam logic [9:0] PCC_IDX_UPDATE     = 10'h232;
   localparam logic [7:0] PCC_UPDATE_KEY     = 8'h01;
   // Field positions
   localparam int PCC_POWER_LSB  = 0;
   localparam int PCC_PUMP_LSB   = 4;
   localparam int PCC_POL_BIT    = 7;
   localparam int PCC_BYPASS_BIT = 0;
   localparam int PCC_SRC_BIT    = 1;
   // Power field codes
   localparam logic [1:0] PCC_PWR_NORMAL = 2'b00;
   localparam logic [1:0] PCC_PWR_DOWN   = 2'b01;
   // Charge pump mode codes
   localparam logic [2:0] PCC_PUMP_HIZ    = 3'h0;
   localparam logic [2:0] PCC_PUMP_FUP    = 3'h1;
   localparam logic [2:0] PCC_PUMP_FDOWN  = 3'h2;
   localparam logic [2:0] PCC_PUMP_NORMAL = 3'h3;
   // VCO divider reset code, top code and ratio offset
   localparam logic [2:0] PCC_VCO_DIV_RST = 3'b010;
   localparam logic [2:0] PCC_VCO_DIV_MAX = 3'b100;
   localparam logic [2:0] PCC_DIV_OFFSET  = 3'h2;
   // Pump current step and top, in microamps
   localparam int PCC_PUMP_STEP_UA = 600;
   localparam int PCC_PUMP_TOP_UA  = 4800;
   // Anti-backlash hold, one cycle more than base plus the two-bit setting
   localparam logic [2:0] PCC_ABL_BASE = 3'h1;
   // Calibration length in reference edges
   localparam logic [7:0] PCC_CAL_EDGES = 8'h10;
   // Calibration sequencer, Gray coded
   typedef enum logic [1:0] {
      PCC_CAL_IDLE = 2'b00,
      PCC_CAL_RUN  = 2'b01,
      PCC_CAL_DONE = 2'b11
   } pcc_cal_e;
   typedef struct packed {
      logic [1:0] power;
      logic [2:0] pump;
      logic       pol;
      logic [1:0] abl;
      logic       cal;
      logic [2:0] cur;
      logic [2:0] vdiv;
      logic       bypass;
      logic       src_vco;
   } pcc_cfg_s;
endpackage

// [verif/pcc_ref_model.sv]
`timescale 1ns/10ps
`default_nettype none
// Reference and feedback divider outputs, both held low while stopped
module pcc_ref_model (
   input  wire logic       i_clk,     // Bench clock
   input  wire logic       i_run,     // Divider edges present
   input  wire logic [4:0] i_delay,   // Feedback lag in clocks
   output logic            o_ref_div, // Reference divider output
   output logic            o_fb_div   // Feedback divider output
);
   logic [4:0] cnt;

   initial begin
      cnt = 5'h0;
      o_ref_div = 1'b0;
      o_fb_div = 1'b0;
   end

   // 32-clock frame with 8-clock pulses; slow edges keep the source far under the divider limit
   // Bench keeps i_run high across calibration so the reference never stalls
   always @(posedge i_clk) begin
      cnt <= cnt + 5'h1;
      o_ref_div <= i_run && (cnt < 5'h8);
      o_fb_div <= i_run && (5'(cnt - i_delay) < 5'h8);
   end
endmodule
`default_nettype wire

// [verif/pll_clock_path_config_tb.sv]
`timescale 1ns/10ps
`default_nettype none
module pll_clock_path_config_tb import pcc_pkg::*;;
   localparam int FB_LAG = 6;
   logic i_clk, i_reset, i_psel, i_penable, i_pwrite, i_ref_div, i_fb_div;
   logic [11:0] i_paddr;
   logic [31:0] i_pwdata, o_prdata, rdv;
   logic o_pready, o_pslverr, o_pll_power_down, o_pll_enable, o_pfd_invert, o_pump_up, o_pump_down;
   logic o_div_bypass, o_src_vco, o_cal_busy, o_cal_done, err, run;
   logic [1:0] o_backlash_sel;
   logic [2:0] o_pump_current_code, o_vco_div_ratio;
   int n_fail, cmp_count, n;

   pcc_top DUT (.i_clk(i_clk), .i_reset(i_reset), .i_psel(i_psel), .i_penable(i_penable),
      .i_pwrite(i_pwrite), .i_paddr(i_paddr), .i_pwdata(i_pwdata), .o_pready(o_pready),
      .o_prdata(o_prdata), .o_pslverr(o_pslverr), .i_ref_div(i_ref_div), .i_fb_div(i_fb_div),
      .o_pll_power_down(o_pll_power_down), .o_pll_enable(o_pll_enable), .o_pfd_invert(o_pfd_invert),
      .o_backlash_sel(o_backlash_sel), .o_pump_up(o_pump_up), .o_pump_down(o_pump_down),
      .o_pump_current_code(o_pump_current_code), .o_vco_div_ratio(o_vco_div_ratio),
      .o_div_bypass(o_div_bypass), .o_src_vco(o_src_vco), .o_cal_busy(o_cal_busy), .o_cal_done(o_cal_done));
   pcc_ref_model partner (.i_clk(i_clk), .i_run(run), .i_delay(5'(FB_LAG)), .o_ref_div(i_ref_div),
      .o_fb_div(i_fb_div));

   // Clock, 8 ns period
   initial begin
      i_clk = 1'b0;
      forever #4 i_clk = ~i_clk;
   end

   task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask
   task automatic cmp_pin(input logic [7:0] got, input logic [7:0] exp);
      cmp_count++;
      if (got !== exp) begin
         n_fail++;
         $display("mismatch at %0t: pin %h expected %h", $time, got, exp);
      end
   endtask

   // One APB transfer; request held until pready is seen at an edge
   task automatic apb(input logic wr, input logic [9:0] idx, input logic [31:0] wd);
      @(posedge i_clk);
      i_psel <= 1'b1;
      i_penable <= 1'b0;
      i_pwrite <= wr;
      i_paddr <= {idx, 2'b00};
      i_pwdata <= wd;
      @(posedge i_clk);
      i_penable <= 1'b1;
      n = 0;
      do begin
         @(posedge i_clk);
         n++;
      end while (o_pready !== 1'b1 && n < 50);
      rdv = o_prdata;
      err = o_pslverr;
      i_psel <= 1'b0;
      i_penable <= 1'b0;
      if (n >= 50) begin
         cmp_pin(8'h0, 8'h1); // Ready never came
         report_and_stop();
      end
   endtask
   task automatic wr(input logic [9:0] idx, input logic [31:0] wd);
      apb(1'b1, idx, wd);
   endtask
   task automatic rd_chk(input logic [9:0] idx, input logic [31:0] exp);
      apb(1'b0, idx, 32'h0000_0000);
      cmp_data(rdv, exp);
   endtask
   // Commit staged values; outputs settle one edge after the write lands
   task automatic commit;
      wr(PCC_IDX_UPDATE, {24'h00_0000, PCC_UPDATE_KEY});
      @(posedge i_clk);
      #1;
   endtask
   // Count drive cycles over two frames after the loop has settled
   task automatic measure(input logic inv, input logic [1:0] abl);
      int u;
      int d;
      int b;
      u = 0;
      d = 0;
      b = 0;
      repeat (64) @(posedge i_clk);
      repeat (64) begin
         @(posedge i_clk);
         #1;
         if (o_pump_up && !o_pump_down) u++;
         if (o_pump_down && !o_pump_up) d++;
         if (o_pump_up && o_pump_down) b++;
      end
      cmp_data(32'(inv ? d : u), 32'(2 * FB_LAG));
      cmp_data(32'(inv ? u : d), 32'h0000_0000);
      cmp_data(32'(b), 32'(2 * (abl + 2)));
   endtask

   task automatic report_and_stop;
      $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
      if (n_fail == 0 && cmp_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask

   // Hang guard, well beyond the expected run
   initial begin
      #(8 * 30000);
      n_fail++;
      report_and_stop();
   end

   initial begin
      {i_reset, i_psel, i_penable, i_pwrite, run} = 5'b10000;
      i_paddr = 12'h000;
      i_pwdata = 32'h0000_0000;
      repeat (20) @(posedge i_clk);
      i_reset <= 1'b0;
      @(posedge i_clk);
      #1;
      cmp_pin(o_pll_power_down, 8'h01);
      cmp_pin(o_vco_div_ratio, 8'h04);
      rd_chk(PCC_IDX_PLL_CTRL, 32'h0000_0001);
      rd_chk(PCC_IDX_SRC_SEL, 32'h0000_0000);
      apb(1'b0, 10'h3FF, 32'h0000_0000);
      cmp_data({31'h0, err}, 32'h0000_0001);
      $display("test reset and map done");
      // Staged writes stay invisible until the update key
      wr(PCC_IDX_PLL_CTRL, 32'h0000_0030);
      wr(PCC_IDX_SRC_SEL, 32'h0000_0001);
      wr(PCC_IDX_UPDATE, 32'h0000_0002);
      @(posedge i_clk);
      #1;
      cmp_pin(o_pll_power_down, 8'h01);
      cmp_pin(o_div_bypass, 8'h00);
      rd_chk(PCC_IDX_SRC_SEL, 32'h0000_0001);
      commit();
      cmp_pin(o_pll_enable, 8'h01);
      cmp_pin(o_div_bypass, 8'h01);
      cmp_pin(o_src_vco, 8'h00);
      // Codes above four clamp to the top ratio
      for (int c = 0; c < 8; c++) begin
         wr(PCC_IDX_VCO_DIV, 32'(c));
         commit();
         cmp_pin(o_vco_div_ratio, 8'((c > 4) ? 6 : c + 2));
      end
      for (int c = 0; c < 8; c++) begin
         wr(PCC_IDX_PUMP_CUR, 32'(c));
         commit();
         cmp_pin(o_pump_current_code, 8'(c));
      end
      $display("test staging and dividers done");
      // Polarity only counts with the external source
      wr(PCC_IDX_PLL_CTRL, 32'h0000_00B0);
      wr(PCC_IDX_SRC_SEL, 32'h0000_0002);
      commit();
      cmp_pin(o_src_vco, 8'h01);
      cmp_pin(o_pfd_invert, 8'h00);
      wr(PCC_IDX_SRC_SEL, 32'h0000_0000);
      commit();
      cmp_pin(o_pfd_invert, 8'h01);
      run <= 1'b1;
      measure(1'b1, 2'h0);
      wr(PCC_IDX_PLL_CTRL, 32'h0000_0030);
      for (int a = 0; a < 4; a++) begin
         wr(PCC_IDX_BACKLASH, 32'(a));
         commit();
         cmp_pin(o_backlash_sel, 8'(a));
         measure(1'b0, 2'(a));
      end
      $display("test detector done");
      // Stop the dividers only after a feedback edge, so no lone pump request stays pending
      wait (i_fb_div === 1'b1);
      @(posedge i_clk);
      run <= 1'b0;
      repeat (16) @(posedge i_clk);
      for (int m = 0; m < 8; m++) begin
         wr(PCC_IDX_PLL_CTRL, 32'(m << 4));
         commit();
         cmp_pin({o_pump_up, o_pump_down}, {6'h0, m == 1, m == 2});
      end
      wr(PCC_IDX_PLL_CTRL, 32'h0000_0011);
      commit();
      cmp_pin({o_pll_power_down, o_pll_enable, o_pump_up}, 8'h04);
      $display("test pump modes done");
      // Calibration with the reference running throughout
      run <= 1'b1;
      wr(PCC_IDX_PLL_CTRL, 32'h0000_0030);
      for (int k = 0; k < 2; k++) begin
         wr(PCC_IDX_CAL_CTRL, 32'h0000_0001);
         commit();
         cmp_pin(o_cal_busy, 8'h01);
         n = 0;
         while (o_cal_done !== 1'b1 && n < 700) begin
            @(posedge i_clk);
            #1;
            n++;
         end
         cmp_pin(o_cal_done, 8'h01);
         wr(PCC_IDX_STATUS, 32'h0000_0003);
         rd_chk(PCC_IDX_STATUS, 32'h0000_0002);
         wr(PCC_IDX_CAL_CTRL, 32'h0000_0000);
         commit();
         cmp_pin(o_cal_done, 8'h00);
      end
      $display("test calibration done");
      report_and_stop();
   end
endmodule
`default_nettype wire
